// *** rtl/vv_cfg.svh ***
// offsets, field positions, reset values and timing counts of the voice vlan classifier
`ifndef VV_CFG_SVH
`define VV_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define VV_OFF_CTRL      8'h00
`define VV_OFF_VID       8'h04
`define VV_OFF_AGE       8'h08
`define VV_OFF_PEN       8'h0c
`define VV_OFF_ACT       8'h10
`define VV_OFF_OIDX      8'h14
`define VV_OFF_ODAT      8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define VV_CTRL_EN       0
`define VV_CTRL_RMK      1
`define VV_CTRL_PCP_LSB  4
`define VV_ODAT_VLD      24

// ----------------------------------------------------------------
// sizes, reset values and limits
// ----------------------------------------------------------------
`define VV_NPORT         8
`define VV_NOUI          8
`define VV_FIFO_DEPTH    16
`define VV_RST_PCP       3'h6
`define VV_VID_NONE      12'h000
`define VV_RST_AGE       17'h005a0
`define VV_AGE_MIN       17'h0001e
`define VV_AGE_MAX       17'h10000

// ----------------------------------------------------------------
// timing: one minute of aging at the core clock rate
// ----------------------------------------------------------------
`define VV_MIN_NS        64'd60000000000
`define VV_CLK_NS        64'd10

`endif

// *** rtl/vv_pkg.sv ***
// types shared by the voice vlan classifier modules
package vv_pkg;
   // descriptor handed downstream after classification
   typedef struct packed {
      logic [2:0]  port;
      logic [11:0] vid;
      logic [2:0]  pcp;
      logic        voice;
   } vv_out_t;
   // descriptor of an ingress frame
   typedef struct packed {
      logic [2:0]  port;
      logic [47:0] smac;
      logic [11:0] vid;
      logic [2:0]  pcp;
   } vv_in_t;
endpackage

// *** rtl/vv_stream_if.sv ***
// valid/ready stream carrier between the classifier and its fifo
`timescale 1ns/10ps
interface vv_stream_if #(parameter int W = 8);
   logic [W-1:0] data;   // payload
   logic         valid;  // payload present
   logic         ready;  // sink takes payload
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface // vv_stream_if

// *** rtl/vv_fifo.sv ***
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
module vv_fifo #(
   parameter int W     = 19,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic    i_mclk,
   input wire logic    i_rst_n,
   // filling and draining sides
   vv_stream_if.snk    s_in,
   vv_stream_if.src    s_out
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0]  mem [DEPTH];  // storage flops
   logic [AW-1:0] wptr;         // write index
   logic [AW-1:0] rptr;         // read index
   logic [AW:0]   count;        // words held
   wire           push;         // word enters
   wire           pop;          // word leaves

   // ----------------------------------------------------------------
   // handshakes; full and empty come straight from the count
   // ----------------------------------------------------------------
   assign s_in.ready  = (count != (AW+1)'(DEPTH));
   assign s_out.valid = (count != '0);
   assign s_out.data  = mem[rptr];
   assign push        = s_in.valid & s_in.ready;
   assign pop         = s_out.valid & s_out.ready;

   // pointers and count
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         wptr  <= '0;
         rptr  <= '0;
         count <= '0;
      end else begin
         if (push) wptr <= wptr + 1'b1;
         if (pop) rptr <= rptr + 1'b1;
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // storage is not reset; only valid words are ever read
   always_ff @(posedge i_mclk) begin
      if (push) mem[wptr] <= s_in.data;
   end
endmodule // vv_fifo

// *** rtl/vv_classifier.sv ***
// voice vlan classifier: oui match, vlan steering, 802.1p remark, per-port aging
//
// Function
// - classify each frame by its source mac
// - oui table hit means voice, voice vlan
// - global enable gates classification, default off
// - voice vid only 1 to 4095, none first
// - port leaves after aging time, default 1440
// - optional remark of voice priority, default 6
// - voice frames leave at voice priority when remark is on, else at their own priority
// - membership follows source mac, not port
// - per-port participation enable, default off
// - 24-bit oui against top mac bytes
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "vv_cfg.svh"
module vv_classifier import vv_pkg::*; #(
   parameter logic [32:0] CYC_PER_MIN = 33'(`VV_MIN_NS / `VV_CLK_NS)
) (
   // clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   // apb slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // ingress frame descriptors
   input  wire logic        i_in_valid,
   input  wire logic [2:0]  i_in_port,
   input  wire logic [47:0] i_in_smac,
   input  wire logic [11:0] i_in_vid,
   input  wire logic [2:0]  i_in_pcp,
   output logic             o_in_ready,
   // classified descriptors
   output logic             o_out_valid,
   output logic [2:0]       o_out_port,
   output logic [11:0]      o_out_vid,
   output logic [2:0]       o_out_pcp,
   output logic             o_out_voice,
   input  wire logic        i_out_ready,
   // per-port voice vlan membership
   output logic [7:0]       o_voice_active
);
   localparam int NP = `VV_NPORT;
   localparam int NO = `VV_NOUI;
   localparam int OW = $bits(vv_out_t);

   // ----------------------------------------------------------------
   // configuration and state
   // ----------------------------------------------------------------
   logic          vv_en;             // global enable
   logic          rmk_en;            // 802.1p remark enable
   logic [2:0]    rmk_pcp;           // remark value
   logic [11:0]   voice_vid;         // zero means none set
   logic [16:0]   age_min;           // aging time in minutes
   logic [NP-1:0] port_en;           // per-port participation
   logic [2:0]    oui_idx;           // table entry under edit
   logic [23:0]   oui_tab [NO];      // vendor prefixes
   logic [NO-1:0] oui_vld;           // entry in use
   logic [16:0]   age_cnt [NP];      // minutes of silence per port
   logic [32:0]   presc;             // cycles into current minute
   logic          min_tick;          // one-cycle pulse per minute
   logic          in_vld;            // input stage holds a frame
   vv_in_t        in_d;              // input stage frame

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   wire        acc_ph   = i_psel & i_penable;
   wire        rsp_now  = acc_ph & ~o_pready;        // answer computed here
   wire        wr_fire  = acc_ph & o_pready & i_pwrite & ~o_pslverr;
   wire [11:0] wr_vid   = i_pwdata[11:0];
   wire [16:0] wr_age   = i_pwdata[16:0];
   wire        hit_ctrl = (i_paddr == `VV_OFF_CTRL);
   wire        hit_vid  = (i_paddr == `VV_OFF_VID);
   wire        hit_age  = (i_paddr == `VV_OFF_AGE);
   wire        hit_pen  = (i_paddr == `VV_OFF_PEN);
   wire        hit_act  = (i_paddr == `VV_OFF_ACT);
   wire        hit_oidx = (i_paddr == `VV_OFF_OIDX);
   wire        hit_odat = (i_paddr == `VV_OFF_ODAT);
   wire        mapped   = hit_ctrl | hit_vid | hit_age | hit_pen | hit_act
                          | hit_oidx | hit_odat;
   // out-of-range values are refused rather than clipped
   wire        bad_vid  = hit_vid & ((wr_vid == `VV_VID_NONE) | (|i_pwdata[31:12]));
   wire        bad_age  = hit_age & ((wr_age < `VV_AGE_MIN)
                          | (i_pwdata[31:0] > 32'(`VV_AGE_MAX)));
   wire        wr_err   = i_pwrite & (bad_vid | bad_age | hit_act);
   wire        acc_err  = ~mapped | wr_err;
   wire [31:0] rd_mux   =
      hit_ctrl ? {25'h0, rmk_pcp, 2'h0, rmk_en, vv_en} :
      hit_vid  ? {20'h0, voice_vid} :
      hit_age  ? {15'h0, age_min} :
      hit_pen  ? {24'h0, port_en} :
      hit_act  ? {24'h0, o_voice_active} :
      hit_oidx ? {29'h0, oui_idx} :
      hit_odat ? {7'h0, oui_vld[oui_idx], oui_tab[oui_idx]} : 32'h0;

   // answer one cycle into the access phase
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h0;
      end else begin
         o_pready  <= rsp_now;
         o_pslverr <= rsp_now & acc_err;
         if (rsp_now) o_prdata <= i_pwrite ? 32'h0 : rd_mux;
      end
   end

   // register writes take effect at the completing edge only
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         vv_en     <= 1'b0;
         rmk_en    <= 1'b0;
         rmk_pcp   <= `VV_RST_PCP;
         voice_vid <= `VV_VID_NONE;
         age_min   <= `VV_RST_AGE;
         port_en   <= '0;
         oui_idx   <= 3'h0;
         oui_vld   <= '0;
      end else if (wr_fire) begin
         if (hit_ctrl) begin
            vv_en   <= i_pwdata[`VV_CTRL_EN];
            rmk_en  <= i_pwdata[`VV_CTRL_RMK];
            rmk_pcp <= i_pwdata[`VV_CTRL_PCP_LSB +: 3];
         end
         if (hit_vid) voice_vid <= wr_vid;
         if (hit_age) age_min <= wr_age;
         if (hit_pen) port_en <= i_pwdata[NP-1:0];
         if (hit_oidx) oui_idx <= i_pwdata[2:0];
         if (hit_odat) oui_vld[oui_idx] <= i_pwdata[`VV_ODAT_VLD];
      end
   end

   // prefix storage has no reset; the valid bits guard it
   always_ff @(posedge i_mclk) begin
      if (wr_fire & hit_odat) oui_tab[oui_idx] <= i_pwdata[23:0];
   end

   // ----------------------------------------------------------------
   // input stage; one frame held, ready drops while it waits
   // ----------------------------------------------------------------
   vv_stream_if #(.W(OW)) fifo_wr ();
   vv_stream_if #(.W(OW)) fifo_rd ();

   wire take       = i_in_valid & o_in_ready;
   wire push       = in_vld & fifo_wr.ready;
   wire next_in_vld = take | (in_vld & ~push);

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         in_vld     <= 1'b0;
         o_in_ready <= 1'b0;
      end else begin
         in_vld     <= next_in_vld;
         o_in_ready <= ~next_in_vld;   // costs half rate, keeps ready a flop
      end
   end

   always_ff @(posedge i_mclk) begin
      if (take) in_d <= '{port: i_in_port, smac: i_in_smac,
                          vid: i_in_vid, pcp: i_in_pcp};
   end

   // ----------------------------------------------------------------
   // classification of the held frame
   // ----------------------------------------------------------------
   logic [NO-1:0] oui_hit_vec;
   genvar gi;
   generate
      for (gi = 0; gi < NO; gi++) begin : g_oui
         // only the vendor prefix of the sender is compared
         assign oui_hit_vec[gi] = oui_vld[gi]
                                  & (oui_tab[gi] == in_d.smac[47:24]);
      end
   endgenerate

   wire     oui_hit   = |oui_hit_vec;
   // any enabled port qualifies, so a moved phone is caught again
   wire     is_voice  = vv_en & (voice_vid != `VV_VID_NONE)
                        & port_en[in_d.port] & oui_hit;
   wire     push_voice = push & is_voice;
   vv_out_t cls;

   assign cls.port  = in_d.port;
   assign cls.vid   = is_voice ? voice_vid : in_d.vid;
   assign cls.pcp   = (is_voice & rmk_en) ? rmk_pcp : in_d.pcp;
   assign cls.voice = is_voice;
   assign fifo_wr.data  = cls;
   assign fifo_wr.valid = in_vld;

   vv_fifo #(.W(OW), .DEPTH(`VV_FIFO_DEPTH)) u_fifo (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .s_in    (fifo_wr),
      .s_out   (fifo_rd)
   );

   // ----------------------------------------------------------------
   // output stage; stalls of the consumer back up into the fifo
   // ----------------------------------------------------------------
   wire     out_load = fifo_rd.valid & (~o_out_valid | i_out_ready);
   vv_out_t rd_d;
   assign rd_d          = fifo_rd.data;
   assign fifo_rd.ready = ~o_out_valid | i_out_ready;

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_out_valid <= 1'b0;
         o_out_port  <= 3'h0;
         o_out_vid   <= 12'h000;
         o_out_pcp   <= 3'h0;
         o_out_voice <= 1'b0;
      end else if (out_load) begin
         o_out_valid <= 1'b1;
         o_out_port  <= rd_d.port;
         o_out_vid   <= rd_d.vid;
         o_out_pcp   <= rd_d.pcp;
         o_out_voice <= rd_d.voice;
      end else if (i_out_ready) begin
         o_out_valid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // aging: minute prescaler and per-port silence counters
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         presc    <= '0;
         min_tick <= 1'b0;
      end else begin
         min_tick <= (presc == CYC_PER_MIN - 33'h1);
         presc    <= (presc == CYC_PER_MIN - 33'h1) ? '0 : presc + 33'h1;
      end
   end

   generate
      for (gi = 0; gi < NP; gi++) begin : g_age
         wire hit_here = push_voice & (in_d.port == 3'(gi));
         wire expire   = min_tick & ((age_cnt[gi] + 17'h1) >= age_min);
         // a fresh voice frame wins over an expiry in the same cycle
         always_ff @(posedge i_mclk) begin
            if (!i_rst_n) begin
               o_voice_active[gi] <= 1'b0;
               age_cnt[gi]        <= '0;
            end else if (!vv_en | !port_en[gi]) begin
               o_voice_active[gi] <= 1'b0;
               age_cnt[gi]        <= '0;
            end else if (hit_here) begin
               o_voice_active[gi] <= 1'b1;
               age_cnt[gi]        <= '0;
            end else if (o_voice_active[gi] & min_tick) begin
               o_voice_active[gi] <= ~expire;
               age_cnt[gi]        <= expire ? '0 : age_cnt[gi] + 17'h1;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   wire [2:0]  pv_port = in_d.port;
   wire [16:0] pv_cnt  = age_cnt[pv_port];

   sequence s_access;
      acc_ph & ~o_pready ##1 acc_ph & o_pready;
   endsequence

   property p_disabled_none;
      @(posedge i_mclk) disable iff (!i_rst_n) push & !vv_en |-> !cls.voice;
   endproperty
   a_disabled_none: assert property (p_disabled_none)
      else $error("voice frame while disabled");

   property p_vid_zero_refused;
      @(posedge i_mclk) disable iff (!i_rst_n)
         s_access ##0 (i_pwrite & hit_vid & ((wr_vid == 12'h000) | (i_pwdata > 32'h00000fff)))
         |-> o_pslverr ##1 $stable(voice_vid);
   endproperty
   a_vid_zero_refused: assert property (p_vid_zero_refused)
      else $error("zero voice vid accepted");

   property p_voice_vid;
      @(posedge i_mclk) disable iff (!i_rst_n)
         push & cls.voice |-> cls.vid == voice_vid && voice_vid != 12'h000;
   endproperty
   a_voice_vid: assert property (p_voice_vid)
      else $error("voice frame not in voice vlan");

   property p_match_gives_voice;
      @(posedge i_mclk) disable iff (!i_rst_n)
         push & vv_en & (voice_vid != 12'h000) & port_en[in_d.port]
         & (oui_tab[oui_idx] == in_d.smac[47:24]) & oui_vld[oui_idx] |-> cls.voice;
   endproperty
   a_match_gives_voice: assert property (p_match_gives_voice)
      else $error("prefix match not classified");

   property p_port_gate;
      @(posedge i_mclk) disable iff (!i_rst_n)
         push & !port_en[in_d.port] |-> !cls.voice && cls.vid == in_d.vid;
   endproperty
   a_port_gate: assert property (p_port_gate)
      else $error("voice on disabled port");

   property p_remark;
      @(posedge i_mclk) disable iff (!i_rst_n)
         push & cls.voice |-> cls.pcp == (rmk_en ? rmk_pcp : in_d.pcp);
   endproperty
   a_remark: assert property (p_remark)
      else $error("voice priority wrong");

   property p_restart;
      @(posedge i_mclk) disable iff (!i_rst_n)
         push_voice & !wr_fire |=> o_voice_active[$past(pv_port)]
         && age_cnt[$past(pv_port)] == 17'h0;
   endproperty
   a_restart: assert property (p_restart)
      else $error("aging not restarted");

   property p_expire;
      @(posedge i_mclk) disable iff (!i_rst_n)
         min_tick & o_voice_active[pv_port] & (pv_cnt + 17'h1 >= age_min)
         & !push_voice |=> !o_voice_active[$past(pv_port)];
   endproperty
   a_expire: assert property (p_expire)
      else $error("port kept after aging time");

   property p_age_refused;
      @(posedge i_mclk) disable iff (!i_rst_n)
         s_access ##0 (i_pwrite & bad_age) |-> o_pslverr ##1 $stable(age_min);
   endproperty
   a_age_refused: assert property (p_age_refused)
      else $error("aging out of range accepted");
endmodule // vv_classifier

// *** testbench/vv_port_model.sv ***
// far-side model: a switch port that offers frame descriptors
`timescale 1ns/10ps
module vv_port_model (
   // clock and handshake
   input  wire logic   i_mclk,
   input  wire logic   i_ready,
   // descriptor offered to the classifier
   output logic        o_valid,
   output logic [2:0]  o_port,
   output logic [47:0] o_smac,
   output logic [11:0] o_vid,
   output logic [2:0]  o_pcp
);
   // idle port: nothing offered, fields hold no meaning
   initial begin
      o_valid = 1'b0;
      o_port  = 3'h0;
      o_smac  = 48'h0;
      o_vid   = 12'h0;
      o_pcp   = 3'h0;
   end

   // frame tagged with whatever vid it was given, voice frame or not
   // fields are held until taken or 60 cycles pass, then flipped so stale data never looks valid
   task automatic send(input logic [2:0] p, input logic [47:0] m,
                       input logic [11:0] v, input logic [2:0] c, output bit ok);
      ok = 1'b0;
      o_valid <= 1'b1;
      o_port  <= p;
      o_smac  <= m;
      o_vid   <= v;
      o_pcp   <= c;
      for (int n = 0; n < 60; n++) begin
         @(posedge i_mclk);
         if (i_ready === 1'b1) begin
            ok = 1'b1;
            break;
         end
      end
      o_valid <= 1'b0;
      o_port  <= ~p;
      o_smac  <= ~m;
      o_vid   <= ~v;
      o_pcp   <= ~c;
      @(posedge i_mclk);
   endtask
endmodule // vv_port_model

// *** testbench/voice_vlan_classifier_tb.sv ***
// self-checking bench of the voice vlan classifier
`timescale 1ns/10ps
`include "vv_cfg.svh"
module voice_vlan_classifier_tb import vv_pkg::*;;
   localparam logic [11:0] VOICE_VID = 12'hfff;  // top of the legal vid range
   logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, act;
   logic [31:0] pwdata, prdata;
   logic        in_valid, in_ready, out_valid, out_voice, out_rdy;
   logic [2:0]  in_port, in_pcp, out_port, out_pcp, rpcp;
   logic [47:0] in_smac;
   logic [11:0] in_vid, out_vid;
   logic [23:0] oui;
   logic        stall, rmk;
   int          fails, num_checks, seed;
   bit          ok;
   vv_out_t     fq[$];  // expected descriptors, oldest first
   logic [32:0] aq[$];  // expected {pslverr, prdata}

   initial mclk = 1'b0;
   always #5 mclk = ~mclk;

   // short aging minute keeps the timeout scenario inside the run
   vv_classifier #(.CYC_PER_MIN(33'h14)) dut_u (
      .i_mclk(mclk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_in_valid(in_valid),
      .i_in_port(in_port), .i_in_smac(in_smac), .i_in_vid(in_vid),
      .i_in_pcp(in_pcp), .o_in_ready(in_ready), .o_out_valid(out_valid),
      .o_out_port(out_port), .o_out_vid(out_vid), .o_out_pcp(out_pcp),
      .o_out_voice(out_voice), .i_out_ready(out_rdy), .o_voice_active(act));
   vv_port_model port_u (
      .i_mclk(mclk), .i_ready(in_ready), .o_valid(in_valid), .o_port(in_port),
      .o_smac(in_smac), .o_vid(in_vid), .o_pcp(in_pcp));

   task automatic give_verdict();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic bad(input string s);
      fails++;
      $display("unexpected at %0t: %s", $time, s);
      give_verdict();
   endtask

   // ----------------------------------------
   // apb master: setup, access until pready
   // ----------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] rd, input logic err);
      aq.push_back({err, w ? 32'h0 : rd});
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      penable <= 1'b0;
      @(posedge mclk);
      penable <= 1'b1;
      for (int n = 0; n <= 20; n++) begin
         @(posedge mclk);
         if (pready === 1'b1) break;
         if (n == 20) bad("no pready");
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d, 32'h0, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] v);
      apb(1'b0, a, 32'h0, v, 1'b0);
   endtask
   // membership read over the bus, then checked on the pins themselves
   task automatic act_is(input logic [7:0] v);
      rd(`VV_OFF_ACT, {24'h0, v});
      num_checks++;
      if (act !== v) begin
         fails++;
         $display("unexpected at %0t: membership pins %h", $time, act);
      end
   endtask

   // source mac that carries the programmed prefix
   function automatic logic [47:0] vm();
      return {oui, 24'($random(seed))};
   endfunction

   // note the expected result, then let the port offer the frame
   task automatic frame(input logic [2:0] p, input logic [47:0] m, input logic v);
      logic [2:0]  c;
      logic [11:0] t;
      c = 3'($random(seed));
      t = 12'($random(seed));
      fq.push_back('{p, v ? VOICE_VID : t, (v && rmk) ? rpcp : c, v});
      port_u.send(p, m, t, c, ok);
      if (!ok) bad("frame not taken");
   endtask

   task automatic drain();
      for (int n = 0; fq.size() > 0; n++) begin
         @(posedge mclk);
         if (n == 400) bad("output stalled");
      end
   endtask

   // consumer with random back-pressure
   always @(posedge mclk) begin
      int r;
      r = $random(seed);
      out_rdy <= !stall && r[0];
   end

   // ----------------------------------------
   // monitor: oldest note against each result
   // ----------------------------------------
   always @(posedge mclk) begin
      vv_out_t     e;
      logic [32:0] ea;
      if (rst_n === 1'b1 && out_valid === 1'b1 && out_rdy === 1'b1) begin
         num_checks++;
         e = fq.size() ? fq.pop_front() : 'x;
         if ({out_port, out_vid, out_pcp, out_voice} !== e) begin
            fails++;
            $display("unexpected at %0t: descriptor %h", $time, e);
         end
      end
      if (pready === 1'b1) begin
         num_checks++;
         ea = aq.size() ? aq.pop_front() : 'x;
         if ({pslverr, prdata} !== ea) begin
            fails++;
            $display("unexpected at %0t: apb answer, want %h", $time, ea);
         end
      end
   end

   initial begin
      repeat (20000) @(posedge mclk);
      bad("run too long");
   end

   initial begin
      seed = 32'h2ba177af;
      {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      {stall, rmk, rpcp} = '0;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      oui = 24'($random(seed));
      rd(`VV_OFF_CTRL, 32'h60);
      rd(`VV_OFF_VID, 32'h0);
      rd(`VV_OFF_AGE, 32'h5a0);
      rd(`VV_OFF_PEN, 32'h0);
      rd(`VV_OFF_ACT, 32'h0);
      apb(1'b0, 8'h1c, 32'h0, 32'h0, 1'b1);
      wr(`VV_OFF_VID, 32'h1000, 1'b1);
      wr(`VV_OFF_VID, 32'h1001, 1'b1);
      wr(`VV_OFF_AGE, 32'h1d, 1'b1);
      wr(`VV_OFF_AGE, 32'h10001, 1'b1);
      wr(`VV_OFF_AGE, 32'h10000, 1'b0);
      rd(`VV_OFF_AGE, 32'h10000);
      wr(`VV_OFF_AGE, 32'h1e, 1'b0);
      wr(`VV_OFF_ACT, 32'hff, 1'b1);
      wr(`VV_OFF_OIDX, 32'h7, 1'b0);
      wr(`VV_OFF_ODAT, {8'h01, oui}, 1'b0);
      rd(`VV_OFF_ODAT, {8'h01, oui});
      wr(`VV_OFF_VID, {20'h0, VOICE_VID}, 1'b0);
      wr(`VV_OFF_PEN, 32'h05, 1'b0);
      frame(3'h0, vm(), 1'b0);
      // spanning tree is taken as already off before the enable goes up
      wr(`VV_OFF_CTRL, 32'h61, 1'b0);
      frame(3'h0, vm(), 1'b1);
      frame(3'h1, vm(), 1'b0);
      frame(3'h2, {oui ^ 24'h1, oui}, 1'b0);
      frame(3'h2, vm(), 1'b1);
      drain();
      act_is(8'h05);
      rmk = 1'b1;
      for (int k = 0; k < 8; k++) begin
         rpcp = 3'(k);
         wr(`VV_OFF_CTRL, {25'h0, 3'(k), 4'h3}, 1'b0);
         frame(3'h0, vm(), 1'b1);
      end
      rd(`VV_OFF_CTRL, 32'h73);
      // port 2 goes quiet, port 0 is refreshed half way
      frame(3'h2, vm(), 1'b1);
      repeat (400) @(posedge mclk);
      frame(3'h0, vm(), 1'b1);
      repeat (400) @(posedge mclk);
      act_is(8'h01);
      repeat (300) @(posedge mclk);
      act_is(8'h00);
      frame(3'h0, vm(), 1'b1);
      drain();
      act_is(8'h01);
      wr(`VV_OFF_CTRL, 32'h60, 1'b0);
      act_is(8'h00);
      frame(3'h0, vm(), 1'b0);
      // path must be empty first: the 18 frames below fill it exactly
      drain();
      // fill input stage, fifo and output stage while the consumer stalls
      stall <= 1'b1;
      for (int k = 0; k < 18; k++) frame(3'h1, vm(), 1'b0);
      repeat (4) @(posedge mclk);
      num_checks++;
      if (in_ready !== 1'b0) begin
         fails++;
         $display("unexpected at %0t: full path still takes frames", $time);
      end
      stall <= 1'b0;
      drain();
      give_verdict();
   end
endmodule // voice_vlan_classifier_tb
